/* File: design/srs_pkg.sv */
// Purpose: constants for the supply regulator supervision register bank
// Assumes: word-addressed registers, 8-bit data in the low bits of a word
// Notes:   offsets are word indices; byte address is four times the index
package srs_pkg;
   localparam int          ADDR_W            = 10;
   localparam logic [31:0] PMU_BASE          = 32'h5000_4000;
   localparam logic [9:0]  OFS_MAIN_STATUS   = 10'h004;
   localparam logic [9:0]  OFS_EXT_CONTROL   = 10'h008;
   localparam logic [9:0]  OFS_WAKE_FAIL     = 10'h080;
   // main supply status fields
   localparam int          MS_CORE_OV        = 0;
   localparam int          MS_CORE_OL        = 1;
   localparam int          MS_CORE_IRQ_EN    = 2;
   localparam int          MS_PAD_OV         = 4;
   localparam int          MS_PAD_OL         = 5;
   localparam int          MS_PAD_IRQ_EN     = 6;
   // external supply control fields
   localparam int          EC_ENABLE         = 0;
   localparam int          EC_EXT_CYCLIC_USE_ENABLE         = 1;
   localparam int          EC_FAIL_EN        = 2;
   localparam int          EC_SHORT          = 3;
   localparam int          EC_OV             = 4;
   localparam int          EC_OL             = 5;
   localparam int          EC_RANGE_WIDE     = 6;
   localparam int          EC_RANGE_NARROW   = 7;
   localparam int          WF_EXT_SHORT      = 2;
   localparam logic [7:0]  RESET_BYTE        = 8'h00;
   localparam logic [31:0] READ_ZERO         = 32'h0000_0000;
   // timing
   localparam int          CLK_HZ            = 50_000_000;
   localparam int          OVL_FILTER_US     = 290;
   localparam int          OVL_FILTER_CYC    = OVL_FILTER_US * (CLK_HZ / 1_000_000);
   localparam int          BLANK_US          = 100;
   localparam int          BLANK_CYC         = BLANK_US * (CLK_HZ / 1_000_000);
endpackage

/* File: design/srs_supply_regs.sv */
// Operation
// - bit 6 of main status enables pad supply interrupts
// - bit 2 of main status enables core supply interrupts
// - overload flags bit 5 pad, bit 1 core, read-only live
// - overvoltage flags bit 4 pad, bit 0 core, read-only live
// - overload lasting past 290 us filter forces sleep mode
// - bits 7 and 3 of main status read zero, ignore writes
// - main status reset by type-zero reset
// - external control reset by type-three, its short flag by type-zero
// - bit 0 switches external regulator on or off
// - cyclic sense use needs both cyclic bit and enable bit
// - external diagnostics raise NMI only with fail enable and supply NMI enable
// - short flag bit 3 set on undervoltage, regulator switches off
// - low input supply dragging output down also sets short flag
// - external overload flag bit 5 read-only, self-clearing
// - external overvoltage flag bit 4 read-only, self-clearing
// - range bits: 7 narrow 250 mV window, 6 wide 500 mV window
// - overcurrent blanked for a set time after switch-on
// - main status at 0x004, external control at 0x008, word addressed
// - pad undervoltage gives interrupt and undervoltage reset
// - external failure in stop mode wakes system, records wake-fail flag
//
// Purpose: supervision and control registers for pad, core and external supplies
// Assumes: analog comparator outputs arrive asynchronously; register port on clk
// Notes:   reset_type0_n is the deeper class; reset_n is the type-three class
`timescale 1ns/1ns
module srs_supply_regs
   import srs_pkg::*;
#(
   parameter int OVL_FILTER_CYCLES = OVL_FILTER_CYC,
   parameter int BLANK_CYCLES      = BLANK_CYC
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              reset_type0_n,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wdata,
   input  wire logic              write_strobe,
   input  wire logic              read_strobe,
   output      logic [31:0]       rdata,
   input  wire logic              pad_supply_overload,
   input  wire logic              pad_supply_overvoltage,
   input  wire logic              pad_supply_undervoltage,
   input  wire logic              core_supply_overload,
   input  wire logic              core_supply_overvoltage,
   input  wire logic              ext_undervoltage,
   input  wire logic              ext_overload,
   input  wire logic              ext_overvoltage,
   input  wire logic              ext_range_narrow,
   input  wire logic              ext_range_wide,
   input  wire logic              supply_nmi_enable,
   input  wire logic              stop_mode,
   output      logic              ext_regulator_on,
   output      logic              ext_cyclic_sense_ok,
   output      logic              pad_supply_irq,
   output      logic              core_supply_irq,
   output      logic              ext_supply_nmi,
   output      logic              sleep_request,
   output      logic              pad_undervoltage_irq,
   output      logic              undervoltage_reset,
   output      logic              stop_wake
);

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;

   assign raw_in = {pad_supply_undervoltage, ext_range_wide, ext_range_narrow,
                    ext_overvoltage, ext_overload, ext_undervoltage,
                    core_supply_overvoltage, core_supply_overload,
                    pad_supply_overvoltage, pad_supply_overload};

   // comparators are analog and asynchronous to clk
   always_ff @(posedge clk or negedge reset_type0_n) begin
      if (!reset_type0_n) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   wire pad_ol   = sync2[0];
   wire pad_ov   = sync2[1];
   wire core_ol  = sync2[2];
   wire core_ov  = sync2[3];
   wire ext_uv   = sync2[4];
   wire ext_ol   = sync2[5];
   wire ext_ov   = sync2[6];
   wire ext_nar  = sync2[7];
   wire ext_wide = sync2[8];
   wire pad_uv   = sync2[9];

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   wire sel_main = (addr == OFS_MAIN_STATUS);
   wire sel_ext  = (addr == OFS_EXT_CONTROL);
   wire sel_wake = (addr == OFS_WAKE_FAIL);
   wire wr_main  = write_strobe && sel_main;
   wire wr_ext   = write_strobe && sel_ext;
   wire wr_wake  = write_strobe && sel_wake;

   logic       pad_irq_en;
   logic       core_irq_en;
   logic       ext_enable;
   logic       ext_ext_cyclic_use_enable;
   logic       ext_fail_en;
   logic       ext_short;
   logic       wake_ext_short;
   logic [7:0] main_view;
   logic [7:0] ext_view;
   logic [7:0] wake_view;

   // ---------------------------------------------------------------
   // main supply status
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_type0_n) begin
      if (!reset_type0_n) begin
         pad_irq_en  <= RESET_BYTE[0];
         core_irq_en <= RESET_BYTE[0];
      end else if (wr_main) begin
         pad_irq_en  <= wdata[MS_PAD_IRQ_EN];
         core_irq_en <= wdata[MS_CORE_IRQ_EN];
      end
   end

   always_comb begin
      main_view                 = RESET_BYTE;
      main_view[MS_PAD_IRQ_EN]  = pad_irq_en;
      main_view[MS_PAD_OL]      = pad_ol;
      main_view[MS_PAD_OV]      = pad_ov;
      main_view[MS_CORE_IRQ_EN] = core_irq_en;
      main_view[MS_CORE_OL]     = core_ol;
      main_view[MS_CORE_OV]     = core_ov;
   end

   assign pad_supply_irq  = pad_irq_en && (pad_ol || pad_ov);
   assign core_supply_irq = core_irq_en && (core_ol || core_ov);
   assign pad_undervoltage_irq = pad_uv;
   assign undervoltage_reset   = pad_uv;

   // ---------------------------------------------------------------
   // overload filter toward sleep
   // ---------------------------------------------------------------
   logic [31:0] ovl_count;
   logic        sleep_latch;
   wire         any_ovl = pad_ol || core_ol;

   // sleep request holds until deep reset; power-down clears it anyway
   always_ff @(posedge clk or negedge reset_type0_n) begin
      if (!reset_type0_n) begin
         ovl_count   <= '0;
         sleep_latch <= 1'b0;
      end else if (!any_ovl) begin
         ovl_count <= '0;
      end else if (ovl_count >= 32'(OVL_FILTER_CYCLES)) begin
         sleep_latch <= 1'b1;
      end else begin
         ovl_count <= ovl_count + 32'd1;
      end
   end
   assign sleep_request = sleep_latch;

   // ---------------------------------------------------------------
   // external supply control
   // ---------------------------------------------------------------
   logic [31:0] blank_count;
   wire         blanking   = (blank_count != '0);
   wire         short_hit  = ext_enable && ext_uv && !blanking;
   wire         ext_ol_vis = ext_ol && !blanking;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ext_enable  <= RESET_BYTE[0];
         ext_ext_cyclic_use_enable  <= RESET_BYTE[0];
         ext_fail_en <= RESET_BYTE[0];
         blank_count <= '0;
      end else begin
         if (short_hit) begin
            ext_enable <= 1'b0;
         end else if (wr_ext) begin
            // a set short flag keeps the regulator off
            ext_enable <= wdata[EC_ENABLE] && !ext_short;
         end
         if (wr_ext) begin
            ext_ext_cyclic_use_enable  <= wdata[EC_EXT_CYCLIC_USE_ENABLE];
            ext_fail_en <= wdata[EC_FAIL_EN];
         end
         if (wr_ext && wdata[EC_ENABLE] && !ext_enable && !ext_short) begin
            blank_count <= 32'(BLANK_CYCLES);
         end else if (blanking) begin
            blank_count <= blank_count - 32'd1;
         end
      end
   end

   // set wins over a software clear in the same cycle
   always_ff @(posedge clk or negedge reset_type0_n) begin
      if (!reset_type0_n) begin
         ext_short <= RESET_BYTE[0];
      end else if (short_hit) begin
         ext_short <= 1'b1;
      end else if (wr_ext && !wdata[EC_SHORT]) begin
         ext_short <= 1'b0;
      end
   end

   always_comb begin
      ext_view                  = RESET_BYTE;
      ext_view[EC_ENABLE]       = ext_enable;
      ext_view[EC_EXT_CYCLIC_USE_ENABLE]       = ext_ext_cyclic_use_enable;
      ext_view[EC_FAIL_EN]      = ext_fail_en;
      ext_view[EC_SHORT]        = ext_short;
      ext_view[EC_OV]           = ext_ov;
      ext_view[EC_OL]           = ext_ol_vis;
      ext_view[EC_RANGE_WIDE]   = ext_wide;
      ext_view[EC_RANGE_NARROW] = ext_nar;
   end

   wire ext_fault = ext_short || ext_ol_vis || ext_ov;

   assign ext_regulator_on    = ext_enable && !ext_short;
   assign ext_cyclic_sense_ok = ext_ext_cyclic_use_enable && ext_enable;
   assign ext_supply_nmi      = ext_fail_en && supply_nmi_enable && ext_fault;

   // ---------------------------------------------------------------
   // stop-mode wake on external failure
   // ---------------------------------------------------------------
   wire stop_fail = stop_mode && ext_fault;

   always_ff @(posedge clk or negedge reset_type0_n) begin
      if (!reset_type0_n) begin
         wake_ext_short <= 1'b0;
      end else if (stop_fail) begin
         wake_ext_short <= 1'b1;
      end else if (wr_wake && !wdata[WF_EXT_SHORT]) begin
         wake_ext_short <= 1'b0;
      end
   end

   assign stop_wake = stop_fail;

   always_comb begin
      wake_view               = RESET_BYTE;
      wake_view[WF_EXT_SHORT] = wake_ext_short;
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   wire [31:0] read_mux = sel_main ? {24'h000000, main_view} :
                          sel_ext  ? {24'h000000, ext_view}  :
                          sel_wake ? {24'h000000, wake_view} : READ_ZERO;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= READ_ZERO;
      end else if (read_strobe) begin
         rdata <= read_mux;
      end else begin
         rdata <= READ_ZERO;
      end
   end

endmodule

/* File: test/srs_supply_regs_assertions.sv */
// Purpose: port-level checks for the supply supervision register bank
// Assumes: 2-flop input sync, rdata registered one cycle after read_strobe
// Notes:   sees a subset of the top ports, bound by implicit names
`timescale 1ns/1ns
module srs_supply_regs_assertions
   import srs_pkg::*;
#(
   parameter int OVL_FILTER_CYCLES = 20
) (
   input wire logic              clk,
   input wire logic              reset_n,
   input wire logic              reset_type0_n,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [31:0]       wdata,
   input wire logic              write_strobe,
   input wire logic              read_strobe,
   input wire logic [31:0]       rdata,
   input wire logic              pad_supply_overload,
   input wire logic              pad_supply_overvoltage,
   input wire logic              pad_supply_undervoltage,
   input wire logic              core_supply_overload,
   input wire logic              supply_nmi_enable,
   input wire logic              stop_mode,
   input wire logic              ext_regulator_on,
   input wire logic              ext_cyclic_sense_ok,
   input wire logic              pad_supply_irq,
   input wire logic              ext_supply_nmi,
   input wire logic              sleep_request,
   input wire logic              pad_undervoltage_irq,
   input wire logic              undervoltage_reset,
   input wire logic              stop_wake
);
   // ----------------------------------------
   // helpers and sequences
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n || !reset_type0_n);
   logic [10:0] ovl_cnt;
   // counts raw overload span; saturates so long runs cannot wrap
   always_ff @(posedge clk or negedge reset_type0_n) begin
      if (!reset_type0_n) begin
         ovl_cnt <= 11'h000;
      end else if (!(pad_supply_overload || core_supply_overload)) begin
         ovl_cnt <= 11'h000;
      end else if (ovl_cnt != 11'h7FF) begin
         ovl_cnt <= ovl_cnt + 11'h001;
      end
   end
   sequence s_rd_main;
      read_strobe && addr == OFS_MAIN_STATUS;
   endsequence
   sequence s_uv_held;
      pad_supply_undervoltage [*3];
   endsequence
   sequence s_wr_ext;
      write_strobe && addr == OFS_EXT_CONTROL;
   endsequence
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   AST_RSVD_ZERO: assert property (s_rd_main |=> rdata[31:8] == 24'h0 && !rdata[7] && !rdata[3])
      else $error("reserved main status bits not zero");
   AST_UNMAPPED: assert property (read_strobe && addr != OFS_MAIN_STATUS && addr != OFS_EXT_CONTROL
      && addr != OFS_WAKE_FAIL |=> rdata == READ_ZERO) else $error("unmapped read not zero");
   AST_RDATA_IDLE: assert property (!$past(read_strobe) |-> rdata == READ_ZERO)
      else $error("rdata not zero outside read slot");
   AST_ENABLE_OFF: assert property (s_wr_ext and wdata[0] == 1'b0 |=> !ext_regulator_on)
      else $error("regulator on after enable cleared");
   AST_CYC_NEEDS_EN: assert property (s_wr_ext and wdata[1:0] == 2'b10 |=> !ext_cyclic_sense_ok)
      else $error("cyclic use allowed without enable");
   AST_NMI_GATE: assert property (ext_supply_nmi |-> supply_nmi_enable)
      else $error("nmi without shared enable");
   AST_PAD_IRQ: assert property (pad_supply_irq |-> $past(pad_supply_overload, 2)
      || $past(pad_supply_overvoltage, 2)) else $error("pad irq without flag");
   AST_SLEEP_FILTER: assert property ($rose(sleep_request) |-> ovl_cnt >= OVL_FILTER_CYCLES)
      else $error("sleep before overload filter ran out");
   AST_SLEEP_HOLD: assert property (sleep_request |=> sleep_request)
      else $error("sleep request dropped");
   AST_UV_RESET: assert property (s_uv_held |-> undervoltage_reset && pad_undervoltage_irq)
      else $error("undervoltage not signalled");
   AST_STOP_WAKE: assert property (stop_wake |-> stop_mode)
      else $error("stop wake outside stop mode");
endmodule
bind srs_supply_regs srs_supply_regs_assertions #(.OVL_FILTER_CYCLES(OVL_FILTER_CYCLES)) u_chk (.*);

/* File: test/tb.sv */
// Purpose: self-checking bench for the supply supervision register bank
// Assumes: short filter and blanking counts set at the instance
// Notes:   inputs driven by non-blocking assignment at rising edges or 1 ns after them
`timescale 1ns/1ns
module tb
   import srs_pkg::*;
;
   logic clk, reset_n, reset_type0_n, write_strobe, read_strobe;
   logic [ADDR_W-1:0] addr;
   logic [31:0] wdata, rdata;
   logic pad_supply_overload, pad_supply_overvoltage, pad_supply_undervoltage, core_supply_overload;
   logic core_supply_overvoltage, ext_undervoltage, ext_overload, ext_overvoltage, ext_range_narrow;
   logic ext_range_wide, supply_nmi_enable, stop_mode, ext_regulator_on, ext_cyclic_sense_ok;
   logic pad_supply_irq, core_supply_irq, ext_supply_nmi, sleep_request, pad_undervoltage_irq;
   logic undervoltage_reset, stop_wake;
   int n_mismatch = 0;
   int cmp_count = 0;
   srs_supply_regs #(.OVL_FILTER_CYCLES(20), .BLANK_CYCLES(10)) u_srs_supply_regs (.*);
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic chk1(input string nm, input logic seen, input logic exp);
      chk(nm, {31'h0, seen}, {31'h0, exp});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      write_strobe <= 1'b1;
      @(posedge clk);
      write_strobe <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
      @(posedge clk);
      addr <= a;
      read_strobe <= 1'b1;
      @(posedge clk);
      read_strobe <= 1'b0;
      #1;
      chk(nm, rdata, {24'h0, e});
   endtask
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog and tests
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #40000;
      n_mismatch++;
      end_of_test;
   end
   initial begin
      {reset_n, reset_type0_n, write_strobe, read_strobe, addr, wdata} = '0;
      {pad_supply_overload, pad_supply_overvoltage, pad_supply_undervoltage, core_supply_overload} = '0;
      {core_supply_overvoltage, ext_undervoltage, ext_overload, ext_overvoltage} = '0;
      {ext_range_narrow, ext_range_wide, supply_nmi_enable, stop_mode} = '0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      reset_type0_n <= 1'b1;
      rd(OFS_MAIN_STATUS, 8'h00, "main_reset");
      rd(OFS_EXT_CONTROL, 8'h00, "ext_reset");
      wr(OFS_MAIN_STATUS, 8'hFF);
      rd(OFS_MAIN_STATUS, 8'h44, "main_rw");
      rd(10'h00C, 8'h00, "unmapped");
      @(posedge clk);
      pad_supply_overvoltage <= 1'b1;
      core_supply_overvoltage <= 1'b1;
      wt(4);
      rd(OFS_MAIN_STATUS, 8'h55, "main_ov");
      chk1("pad_irq", pad_supply_irq, 1'b1);
      chk1("core_irq", core_supply_irq, 1'b1);
      wr(OFS_MAIN_STATUS, 8'h00);
      chk1("pad_irq_off", pad_supply_irq, 1'b0);
      chk1("core_irq_off", core_supply_irq, 1'b0);
      pad_supply_overvoltage <= 1'b0;
      core_supply_overvoltage <= 1'b0;
      pad_supply_overload <= 1'b1;
      wt(4);
      rd(OFS_MAIN_STATUS, 8'h20, "pad_ol");
      pad_supply_overload <= 1'b0;
      wt(6);
      chk1("no_sleep", sleep_request, 1'b0);
      core_supply_overload <= 1'b1;
      wt(4);
      rd(OFS_MAIN_STATUS, 8'h02, "core_ol");
      wt(30);
      chk1("sleep", sleep_request, 1'b1);
      core_supply_overload <= 1'b0;
      wt(4);
      chk1("sleep_held", sleep_request, 1'b1);
      reset_type0_n <= 1'b0;
      wt(1);
      reset_type0_n <= 1'b1;
      wt(1);
      chk1("sleep_cleared", sleep_request, 1'b0);
      pad_supply_undervoltage <= 1'b1;
      wt(4);
      chk1("uv_reset", undervoltage_reset, 1'b1);
      chk1("uv_irq", pad_undervoltage_irq, 1'b1);
      pad_supply_undervoltage <= 1'b0;
      wr(OFS_EXT_CONTROL, 8'h02);
      chk1("cyc_no_en", ext_cyclic_sense_ok, 1'b0);
      chk1("ext_off", ext_regulator_on, 1'b0);
      wr(OFS_EXT_CONTROL, 8'h03);
      chk1("ext_on", ext_regulator_on, 1'b1);
      chk1("cyc_ok", ext_cyclic_sense_ok, 1'b1);
      wr(OFS_EXT_CONTROL, 8'h01);
      chk1("cyc_off", ext_cyclic_sense_ok, 1'b0);
      wt(15);
      {ext_overload, ext_overvoltage, ext_range_narrow, ext_range_wide} <= 4'hF;
      wt(4);
      rd(OFS_EXT_CONTROL, 8'hF1, "ext_live");
      // one bit of each pair high, so a swapped bit position shows
      {ext_overload, ext_overvoltage, ext_range_narrow, ext_range_wide} <= 4'h9;
      wt(4);
      rd(OFS_EXT_CONTROL, 8'h61, "ext_live_split");
      {ext_overload, ext_overvoltage, ext_range_narrow, ext_range_wide} <= 4'h0;
      wt(4);
      rd(OFS_EXT_CONTROL, 8'h01, "ext_selfclear");
      ext_undervoltage <= 1'b1;
      stop_mode <= 1'b1;
      supply_nmi_enable <= 1'b1;
      wt(5);
      chk1("short_off", ext_regulator_on, 1'b0);
      rd(OFS_EXT_CONTROL, 8'h08, "short_flag");
      chk1("stop_wake", stop_wake, 1'b1);
      rd(OFS_WAKE_FAIL, 8'h04, "wake_fail");
      wr(OFS_EXT_CONTROL, 8'h0C);
      chk1("nmi", ext_supply_nmi, 1'b1);
      supply_nmi_enable <= 1'b0;
      wt(1);
      chk1("nmi_gated", ext_supply_nmi, 1'b0);
      reset_n <= 1'b0;
      wt(1);
      reset_n <= 1'b1;
      rd(OFS_EXT_CONTROL, 8'h08, "short_kept");
      ext_undervoltage <= 1'b0;
      stop_mode <= 1'b0;
      wr(OFS_EXT_CONTROL, 8'h01);
      chk1("restart_refused", ext_regulator_on, 1'b0);
      wr(OFS_EXT_CONTROL, 8'h00);
      wr(OFS_EXT_CONTROL, 8'h01);
      chk1("restart", ext_regulator_on, 1'b1);
      end_of_test;
   end
endmodule
